// File: hw/phy_framing_pkg.sv
// constants and symbol tables for the phy stream framing block
// assumes a 40 MHz system clock and a 5 Mb/s serial line in the bench
package phy_framing_pkg;

	// ==========================================================
	// timing
	localparam int CLK_PERIOD_NS = 25;
	localparam int BIT_TIME_NS = 200;
	localparam int BIT_CYCLES = BIT_TIME_NS / CLK_PERIOD_NS;
	localparam int HALF_BIT = BIT_CYCLES / 2;
	localparam int DIV_W = $clog2(BIT_CYCLES);
	localparam int NLP_PERIOD_MS = 16;
	localparam int LINK_TIMEOUT_MS = 150;
	localparam int NS_PER_MS = 1000000;
	localparam int CNT_W = 24;
	localparam int RX_QUIET_CYCLES = 2 * BIT_CYCLES;
	localparam int QUIET_W = 5;
	localparam int IDLE_LINK_ONES = 32;
	localparam int ONES_W = 6;
	localparam int LOCK_BITS = 8;
	localparam int STRAP_CYCLES = 3;

	// ==========================================================
	// symbols
	localparam logic [4:0] SYM_J = 5'h18;
	localparam logic [4:0] SYM_K = 5'h11;
	localparam logic [4:0] SYM_T = 5'h0D;
	localparam logic [4:0] SYM_R = 5'h07;
	localparam logic [4:0] SYM_IDLE = 5'h1F;
	localparam logic [4:0] SYM_IDL10 = 5'h1E;
	localparam logic [4:0] SYM_SILENT = 5'h00;
	localparam logic [3:0] PREAMBLE_NIBBLE = 4'h5;
	localparam logic [2:0] SYM_LEN_100 = 3'h5;
	localparam logic [2:0] SYM_LEN_10 = 3'h4;
	localparam logic [4:0] ENC_TABLE [16] = '{
		5'h1E, 5'h09, 5'h14, 5'h15, 5'h0A, 5'h0B, 5'h0E, 5'h0F,
		5'h12, 5'h13, 5'h16, 5'h17, 5'h1A, 5'h1B, 5'h1C, 5'h1D};

	// ==========================================================
	// scrambler
	localparam int SCR_W = 11;
	localparam int SCR_TAP_A = 8;
	localparam int SCR_TAP_B = 10;

	// ==========================================================
	// register map
	localparam int ADDR_W = 4;
	localparam int DATA_W = 16;
	localparam logic [3:0] REG_CONTROL = 4'h0;
	localparam logic [3:0] REG_STATUS = 4'h1;
	localparam logic [3:0] REG_EXT_CONTROL = 4'h2;
	localparam logic [3:0] REG_NEXT_PAGE = 4'h3;
	localparam int CTL_SPEED_BIT = 0;
	localparam int CTL_DUPLEX_BIT = 1;
	localparam int CTL_AN_BIT = 2;
	localparam logic [15:0] CTL_RESET = 16'h0004;
	localparam int ST_LINK = 0;
	localparam int ST_SPEED = 1;
	localparam int ST_AN = 2;
	localparam int ST_PRE_SUPP = 3;
	localparam int ST_NP_PEND = 4;
	localparam int ST_PAR_DET = 5;
	localparam int EXT_ADDR_LSB = 6;
	localparam int ADDR_BITS = 5;
	localparam int NP_W = 11;

	// ==========================================================
	// state types
	typedef enum logic [2:0] {
		TX_IDLE = 3'b000,
		TX_SSD_K = 3'b001,
		TX_DATA = 3'b010,
		TX_ESD_R = 3'b011,
		TX_IDL = 3'b100
	} tx_state_t;

	typedef enum logic [1:0] {
		RX_HUNT = 2'b00,
		RX_SSD = 2'b01,
		RX_FRAME = 2'b10
	} rx_state_t;

endpackage

// File: hw/sync2.sv
// two flip-flop synchroniser for inputs from outside the clock domain
// assumes a synchronous active-low reset on the same clock
`timescale 1ns/1ps
module sync2 #(
	parameter int WIDTH = 1
) (
	// clock and reset
	input wire logic clock,
	input wire logic reset_n,
	// data
	input wire logic [WIDTH-1:0] d,
	output logic [WIDTH-1:0] q
);

	logic [WIDTH-1:0] meta;

	// ==========================================================
	// two stages
	always_ff @(posedge clock)
	begin
		if (!reset_n)
		begin
			meta <= '0;
			q <= '0;
		end
		else
		begin
			meta <= d;
			q <= meta;
		end
	end

endmodule

// File: hw/phy_stream_framing.sv
// nibble to serial framing path of a 10/100 phy, with strap capture
// assumes the MAC runs on CLOCK and the line pins come from outside
//
// Design decisions made here: the register offsets and the address-and-strobe port.
`timescale 1ns/1ps

module phy_stream_framing
	import phy_framing_pkg::*;
#(
	parameter int NLP_PERIOD_CYCLES =
		NLP_PERIOD_MS * (NS_PER_MS / CLK_PERIOD_NS),
	parameter int LINK_TIMEOUT_CYCLES =
		LINK_TIMEOUT_MS * (NS_PER_MS / CLK_PERIOD_NS)
) (
	// clock and reset
	input wire logic CLOCK,
	input wire logic RESET_N,
	// register port
	input wire logic [ADDR_W-1:0] ADDRESS,
	input wire logic [DATA_W-1:0] WRITE_DATA,
	input wire logic WRITE_STROBE,
	input wire logic READ_STROBE,
	output logic [DATA_W-1:0] READ_DATA,
	// MAC transmit
	input wire logic [3:0] TXD,
	input wire logic TX_EN,
	output logic MII_TX_CLK,
	// MAC receive
	output logic [3:0] RXD,
	output logic RX_DV,
	output logic RX_ER,
	output logic MII_RX_CLK,
	// line transmit
	output logic LINE_TX_DATA,
	output logic LINE_TX_CLK,
	output logic LINE_TX_PULSE,
	// line receive
	input wire logic LINE_RX_DATA,
	input wire logic LINE_RX_CLK,
	input wire logic LINE_RX_PULSE,
	// LED and address strap pins
	input wire logic [ADDR_BITS-1:0] LED_IN,
	output logic [ADDR_BITS-1:0] LED_OUT,
	output logic [ADDR_BITS-1:0] LED_OE_N
);

	logic [DATA_W-1:0] control;
	logic [NP_W-1:0] next_page;
	logic np_pending;
	logic speed100;
	logic par_det;
	logic link100;
	logic link10;
	logic link_ok;
	logic [ADDR_BITS-1:0] phy_addr;
	logic [ADDR_BITS-1:0] led_s;
	logic [1:0] strap_cnt;
	logic strapped;
	logic [DIV_W-1:0] div_cnt;
	logic bit_tick;
	tx_state_t tx_state;
	tx_state_t next_tx_state;
	logic [4:0] next_sym;
	logic [4:0] tx_shift;
	logic [2:0] tx_left;
	logic tx_run;
	logic raw_bit;
	logic [SCR_W-1:0] tx_scr;
	logic [CNT_W-1:0] nlp_cnt;
	logic [DIV_W:0] pulse_cnt;
	logic rx_clk_s;
	logic rx_data_s;
	logic rx_clk_d;
	logic rx_tick;
	logic rx_pulse_s;
	logic rx_pulse_d;
	logic [QUIET_W-1:0] quiet_cnt;
	logic rx_quiet;
	logic [SCR_W-1:0] rx_scr;
	logic rd;
	logic [9:0] win;
	logic [ONES_W-1:0] ones_cnt;
	logic idle_seen;
	logic prev_rb;
	logic [3:0] alt_cnt;
	logic [CNT_W-1:0] link_cnt;
	rx_state_t rx_state;
	logic [2:0] rx_cnt;
	logic [3:0] rx_nib;
	logic [3:0] hold;
	logic hold_valid;
	logic [4:0] rx_sym;
	logic [4:0] dec;

	// ==========================================================
	// symbol coding
	function automatic logic [4:0] decode(input logic [4:0] s);
		logic [4:0] r;
		r = 5'h10;
		for (int i = 0; i < 16; i++)
			if (ENC_TABLE[i] == s)
				r = {1'b0, 4'(i)};
		return r;
	endfunction

	function automatic logic [4:0] nib10(input logic [3:0] n);
		return {n[0], n[1], n[2], n[3], 1'b0};
	endfunction

	// ==========================================================
	// strap capture and LEDs
	sync2 #(.WIDTH(ADDR_BITS)) u_led_sync (
		.clock(CLOCK),
		.reset_n(RESET_N),
		.d(LED_IN),
		.q(led_s)
	);

	always_ff @(posedge CLOCK)
	begin
		if (!RESET_N)
		begin
			strap_cnt <= '0;
			strapped <= 1'b0;
			phy_addr <= '0;
		end
		else if (!strapped)
		begin
			strap_cnt <= strap_cnt + 2'h1;
			if (strap_cnt == 2'(STRAP_CYCLES - 1))
			begin
				phy_addr <= led_s;
				strapped <= 1'b1;
			end
		end
	end

	always_ff @(posedge CLOCK)
	begin
		if (!RESET_N)
		begin
			LED_OUT <= '0;
			LED_OE_N <= '1;
		end
		else
		begin
			LED_OE_N <= {ADDR_BITS{~strapped}};
			LED_OUT <= {control[CTL_DUPLEX_BIT], RX_DV, TX_EN, speed100,
				link_ok};
		end
	end

	// ==========================================================
	// registers and negotiation
	assign link_ok = speed100 ? link100 : link10;

	always_ff @(posedge CLOCK)
	begin
		if (!RESET_N)
		begin
			control <= CTL_RESET;
			next_page <= '0;
			np_pending <= 1'b0;
			speed100 <= 1'b0;
			par_det <= 1'b0;
		end
		else
		begin
			if (WRITE_STROBE && ADDRESS == REG_CONTROL)
				control <= WRITE_DATA;
			if (WRITE_STROBE && ADDRESS == REG_NEXT_PAGE)
				next_page <= WRITE_DATA[NP_W-1:0];
			if (WRITE_STROBE && ADDRESS == REG_NEXT_PAGE)
				np_pending <= 1'b1;
			else if (control[CTL_AN_BIT] && link_ok)
				np_pending <= 1'b0;
			if (!control[CTL_AN_BIT])
				speed100 <= control[CTL_SPEED_BIT];
			else if (idle_seen)
				speed100 <= 1'b1;
			else if (link10)
				speed100 <= 1'b0;
			par_det <= control[CTL_AN_BIT] && (idle_seen || link10);
		end
	end

	always_ff @(posedge CLOCK)
	begin
		if (!RESET_N)
			READ_DATA <= '0;
		else if (!READ_STROBE)
			READ_DATA <= '0;
		else
		begin
			READ_DATA <= '0;
			unique case (ADDRESS)
				REG_CONTROL: READ_DATA <= control;
				REG_STATUS:
				begin
					READ_DATA[ST_LINK] <= link_ok;
					READ_DATA[ST_SPEED] <= speed100;
					READ_DATA[ST_AN] <= control[CTL_AN_BIT];
					READ_DATA[ST_PRE_SUPP] <= 1'b1;
					READ_DATA[ST_NP_PEND] <= np_pending;
					READ_DATA[ST_PAR_DET] <= par_det;
				end
				REG_EXT_CONTROL:
					READ_DATA[EXT_ADDR_LSB+:ADDR_BITS] <= phy_addr;
				REG_NEXT_PAGE: READ_DATA[NP_W-1:0] <= next_page;
				default: READ_DATA <= '0;
			endcase
		end
	end

	// ==========================================================
	// transmit bit timing
	assign bit_tick = div_cnt == DIV_W'(BIT_CYCLES - 1);
	assign tx_run = speed100 || tx_state != TX_IDLE;

	always_ff @(posedge CLOCK)
	begin
		if (!RESET_N)
		begin
			div_cnt <= '0;
			LINE_TX_CLK <= 1'b0;
		end
		else
		begin
			div_cnt <= bit_tick ? '0 : div_cnt + DIV_W'(1);
			LINE_TX_CLK <= tx_run && div_cnt >= DIV_W'(HALF_BIT - 1) &&
				!bit_tick;
		end
	end

	// ==========================================================
	// transmit framing
	always_comb
	begin
		next_tx_state = tx_state;
		next_sym = speed100 ? SYM_IDLE : SYM_SILENT;
		unique case (tx_state)
			TX_IDLE:
				if (TX_EN)
				begin
					next_sym = speed100 ? SYM_J : nib10(TXD);
					next_tx_state = speed100 ? TX_SSD_K : TX_DATA;
				end
			TX_SSD_K:
			begin
				next_sym = SYM_K;
				next_tx_state = TX_DATA;
			end
			TX_DATA:
				if (TX_EN)
					next_sym = speed100 ? ENC_TABLE[TXD] : nib10(TXD);
				else
				begin
					next_sym = speed100 ? SYM_T : SYM_IDL10;
					next_tx_state = speed100 ? TX_ESD_R : TX_IDL;
				end
			TX_ESD_R:
			begin
				next_sym = SYM_R;
				next_tx_state = TX_IDLE;
			end
			TX_IDL: next_tx_state = TX_IDLE;
			default: next_tx_state = TX_IDLE;
		endcase
	end

	assign raw_bit = tx_left == 3'h0 ? next_sym[4] : tx_shift[4];

	always_ff @(posedge CLOCK)
	begin
		if (!RESET_N)
		begin
			tx_state <= TX_IDLE;
			tx_shift <= '0;
			tx_left <= '0;
			MII_TX_CLK <= 1'b0;
		end
		else if (bit_tick)
		begin
			MII_TX_CLK <= 1'b0;
			if (tx_left == 3'h0)
			begin
				tx_state <= next_tx_state;
				tx_shift <= {next_sym[3:0], 1'b0};
				tx_left <= (speed100 ? SYM_LEN_100 : SYM_LEN_10) - 3'h1;
				MII_TX_CLK <= 1'b1;
			end
			else
			begin
				tx_shift <= {tx_shift[3:0], 1'b0};
				tx_left <= tx_left - 3'h1;
			end
		end
	end

	always_ff @(posedge CLOCK)
	begin
		if (!RESET_N)
		begin
			tx_scr <= '0;
			LINE_TX_DATA <= 1'b0;
		end
		else if (!strapped)
			tx_scr <= {~led_s, 1'b1, led_s};
		else if (bit_tick)
		begin
			if (speed100)
			begin
				LINE_TX_DATA <= raw_bit ^ tx_scr[SCR_TAP_A] ^ tx_scr[SCR_TAP_B];
				tx_scr <= {tx_scr[SCR_W-2:0],
					raw_bit ^ tx_scr[SCR_TAP_A] ^ tx_scr[SCR_TAP_B]};
			end
			else
				LINE_TX_DATA <= raw_bit;
		end
	end

	// ==========================================================
	// link pulses
	always_ff @(posedge CLOCK)
	begin
		if (!RESET_N)
		begin
			nlp_cnt <= '0;
			pulse_cnt <= '0;
			LINE_TX_PULSE <= 1'b0;
		end
		else
		begin
			LINE_TX_PULSE <= pulse_cnt != '0;
			if (pulse_cnt != '0)
				pulse_cnt <= pulse_cnt - (DIV_W+1)'(1);
			if (speed100 || tx_state != TX_IDLE)
				nlp_cnt <= '0;
			else if (nlp_cnt == CNT_W'(NLP_PERIOD_CYCLES - 1))
			begin
				nlp_cnt <= '0;
				pulse_cnt <= (DIV_W+1)'(BIT_CYCLES);
			end
			else
				nlp_cnt <= nlp_cnt + CNT_W'(1);
		end
	end

	// ==========================================================
	// receive sampling and link watch
	sync2 #(.WIDTH(3)) u_rx_sync (
		.clock(CLOCK),
		.reset_n(RESET_N),
		.d({LINE_RX_CLK, LINE_RX_DATA, LINE_RX_PULSE}),
		.q({rx_clk_s, rx_data_s, rx_pulse_s})
	);

	assign rx_tick = rx_clk_s && !rx_clk_d;
	assign rx_quiet = quiet_cnt == QUIET_W'(RX_QUIET_CYCLES);
	assign rd = rx_data_s ^ rx_scr[SCR_TAP_A] ^ rx_scr[SCR_TAP_B];
	assign idle_seen = ones_cnt == ONES_W'(IDLE_LINK_ONES);

	always_ff @(posedge CLOCK)
	begin
		if (!RESET_N)
		begin
			rx_clk_d <= 1'b0;
			rx_pulse_d <= 1'b0;
			quiet_cnt <= '0;
			rx_scr <= '0;
			win <= '0;
			ones_cnt <= '0;
			prev_rb <= 1'b0;
			alt_cnt <= '0;
		end
		else
		begin
			rx_clk_d <= rx_clk_s;
			rx_pulse_d <= rx_pulse_s;
			if (rx_tick)
				quiet_cnt <= '0;
			else if (!rx_quiet)
				quiet_cnt <= quiet_cnt + QUIET_W'(1);
			if (rx_tick)
			begin
				rx_scr <= {rx_scr[SCR_W-2:0], rx_data_s};
				win <= {win[8:0], rd};
				if (!rd)
					ones_cnt <= '0;
				else if (!idle_seen)
					ones_cnt <= ones_cnt + ONES_W'(1);
				prev_rb <= rx_data_s;
				if (rx_data_s == prev_rb)
					alt_cnt <= '0;
				else if (alt_cnt != 4'hF)
					alt_cnt <= alt_cnt + 4'h1;
			end
			else if (rx_quiet)
			begin
				ones_cnt <= '0;
				prev_rb <= 1'b0;
				alt_cnt <= '0;
			end
		end
	end

	always_ff @(posedge CLOCK)
	begin
		if (!RESET_N)
		begin
			link100 <= 1'b0;
			link10 <= 1'b0;
			link_cnt <= '0;
		end
		else
		begin
			if (idle_seen)
				link100 <= 1'b1;
			else if (rx_quiet)
				link100 <= 1'b0;
			if (rx_pulse_s && !rx_pulse_d)
			begin
				link10 <= 1'b1;
				link_cnt <= '0;
			end
			else if (link_cnt == CNT_W'(LINK_TIMEOUT_CYCLES - 1))
				link10 <= 1'b0;
			else
				link_cnt <= link_cnt + CNT_W'(1);
		end
	end

	// ==========================================================
	// receive framing
	assign rx_sym = {win[3:0], rd};
	assign dec = decode(rx_sym);

	always_ff @(posedge CLOCK)
	begin
		if (!RESET_N)
		begin
			rx_state <= RX_HUNT;
			rx_cnt <= '0;
			rx_nib <= '0;
			hold <= '0;
			hold_valid <= 1'b0;
			RXD <= '0;
			RX_DV <= 1'b0;
			RX_ER <= 1'b0;
			MII_RX_CLK <= 1'b0;
		end
		else
		begin
			MII_RX_CLK <= 1'b0;
			if (rx_quiet)
			begin
				rx_state <= RX_HUNT;
				hold_valid <= 1'b0;
				RX_DV <= 1'b0;
				RX_ER <= 1'b0;
			end
			else if (rx_tick)
			begin
				unique case (rx_state)
					RX_HUNT:
						if (speed100 && {win[8:0], rd} == {SYM_J, SYM_K})
						begin
							RXD <= PREAMBLE_NIBBLE;
							RX_DV <= 1'b1;
							MII_RX_CLK <= 1'b1;
							rx_state <= RX_SSD;
						end
						else if (!speed100 && alt_cnt >= 4'(LOCK_BITS - 1) &&
							rx_data_s != prev_rb && !rx_data_s)
						begin
							rx_state <= RX_FRAME;
							rx_cnt <= '0;
						end
					RX_SSD:
					begin
						RXD <= PREAMBLE_NIBBLE;
						MII_RX_CLK <= 1'b1;
						rx_cnt <= 3'h1;
						rx_state <= RX_FRAME;
					end
					RX_FRAME:
						if (speed100)
						begin
							rx_cnt <= rx_cnt + 3'h1;
							if (rx_cnt == SYM_LEN_100 - 3'h1)
							begin
								rx_cnt <= '0;
								if (rx_sym == SYM_T)
								begin
									RX_DV <= 1'b0;
									RX_ER <= 1'b0;
									rx_state <= RX_HUNT;
								end
								else
								begin
									RXD <= dec[3:0];
									RX_ER <= dec[4];
									MII_RX_CLK <= 1'b1;
								end
							end
						end
						else
						begin
							rx_nib <= {rx_data_s, rx_nib[3:1]};
							rx_cnt <= rx_cnt + 3'h1;
							if (rx_cnt == SYM_LEN_10 - 3'h1)
							begin
								rx_cnt <= '0;
								hold <= {rx_data_s, rx_nib[3:1]};
								hold_valid <= 1'b1;
								if (hold_valid)
								begin
									RXD <= hold;
									RX_DV <= 1'b1;
									MII_RX_CLK <= 1'b1;
								end
							end
						end
					default: rx_state <= RX_HUNT;
				endcase
			end
		end
	end

endmodule

// File: bench/phy_framing_asserts.sv
// port checker for the phy stream framing block
// assumes it is bound to the top module and clocked by CLOCK
`timescale 1ns/1ps
module phy_framing_asserts
	import phy_framing_pkg::*;
(
	// clock and reset
	input wire logic CLOCK,
	input wire logic RESET_N,
	// register port
	input wire logic READ_STROBE,
	input wire logic [DATA_W-1:0] READ_DATA,
	// MAC side
	input wire logic MII_TX_CLK,
	input wire logic MII_RX_CLK,
	input wire logic RX_DV,
	// line side
	input wire logic LINE_TX_DATA,
	input wire logic LINE_TX_CLK,
	input wire logic LINE_TX_PULSE,
	// straps
	input wire logic [ADDR_BITS-1:0] LED_OE_N
);
	// ==========================================================
	// properties
	default clocking @(posedge CLOCK); endclocking
	default disable iff (!RESET_N);

	a_read_idle_zero: assert property (
		!$past(READ_STROBE) |-> READ_DATA == 16'h0000)
		else $error("read data nonzero outside read");
	a_strap_float: assert property (
		$rose(RESET_N) |-> LED_OE_N == 5'h1F)
		else $error("led pins driven during strap");
	a_strap_drive: assert property (
		$rose(RESET_N) |-> ##[1:8] LED_OE_N == 5'h00)
		else $error("led pins not driven after strap");
	a_tx_clk_width: assert property (
		$rose(MII_TX_CLK) |-> MII_TX_CLK [*8] ##1 !MII_TX_CLK)
		else $error("mac tx clock width wrong");
	a_rx_clk_pulse: assert property (
		MII_RX_CLK |=> !MII_RX_CLK)
		else $error("mac rx clock longer than one cycle");
	a_pulse_width: assert property (
		$rose(LINE_TX_PULSE) |-> LINE_TX_PULSE [*8] ##1 !LINE_TX_PULSE)
		else $error("link pulse width wrong");
	a_pulse_quiet: assert property (
		LINE_TX_PULSE |-> !LINE_TX_CLK)
		else $error("link pulse while line clock runs");
	a_line_hold: assert property (
		LINE_TX_CLK && $past(LINE_TX_CLK) |-> $stable(LINE_TX_DATA))
		else $error("line data moved while clock high");
	a_line_half_bit: assert property (
		$rose(LINE_TX_CLK) |-> LINE_TX_CLK [*4] ##1 !LINE_TX_CLK)
		else $error("line clock high phase wrong");
	a_dv_first_nibble: assert property (
		$rose(RX_DV) |-> MII_RX_CLK)
		else $error("rx valid rose without nibble");

	c_frame: cover property ($rose(RX_DV));
	c_pulse: cover property ($rose(LINE_TX_PULSE));
	c_read: cover property (READ_STROBE ##1 READ_DATA != 16'h0000);
endmodule

bind phy_stream_framing phy_framing_asserts u_chk (
	.CLOCK(CLOCK),
	.RESET_N(RESET_N),
	.READ_STROBE(READ_STROBE),
	.READ_DATA(READ_DATA),
	.MII_TX_CLK(MII_TX_CLK),
	.MII_RX_CLK(MII_RX_CLK),
	.RX_DV(RX_DV),
	.LINE_TX_DATA(LINE_TX_DATA),
	.LINE_TX_CLK(LINE_TX_CLK),
	.LINE_TX_PULSE(LINE_TX_PULSE),
	.LED_OE_N(LED_OE_N)
);

// File: bench/mac_model.sv
// MAC transmit side: hands queued nibbles over on each tx clock rise
// assumes the tx clock is synchronous to clock
`timescale 1ns/1ps
module mac_model (
	// clock
	input wire logic clock,
	input wire logic tx_clk,
	// MAC nibbles
	output logic [3:0] txd,
	output logic tx_en
);
	logic [3:0] q[$];
	logic prev = 1'b0;

	initial
	begin
		txd = 4'h0;
		tx_en = 1'b0;
	end

	task push(input logic [3:0] n);
		q.push_back(n);
	endtask

	// ==========================================================
	// change only after the device shows its clock rise
	always @(posedge clock)
	begin
		prev <= tx_clk;
		if (tx_clk && !prev)
		begin
			if (q.size() > 0)
			begin
				txd <= q.pop_front();
				tx_en <= 1'b1;
			end
			else
			begin
				txd <= ~txd;
				tx_en <= 1'b0;
			end
		end
	end
endmodule

// File: bench/phy_stream_framing_test.sv
// self-checking bench: registers, 100M and 10M frames in line loopback
// assumes the line outputs loop back to the line inputs
`timescale 1ns/1ps
module phy_stream_framing_test
	import phy_framing_pkg::*;
;
	logic CLOCK = 1'b0;
	logic RESET_N = 1'b0;
	logic [3:0] ADDRESS = 4'h0;
	logic [15:0] WRITE_DATA = 16'h0000;
	logic WRITE_STROBE = 1'b0;
	logic READ_STROBE = 1'b0;
	logic [4:0] strap = 5'h00;
	wire [15:0] READ_DATA;
	wire [3:0] TXD, RXD;
	wire TX_EN, MII_TX_CLK, RX_DV, RX_ER, MII_RX_CLK;
	wire LINE_TX_DATA, LINE_TX_CLK, LINE_TX_PULSE;
	wire LINE_RX_DATA, LINE_RX_CLK, LINE_RX_PULSE;
	wire [4:0] LED_IN, LED_OUT, LED_OE_N;
	integer seed = 32'hEAF29999;
	int n_errors = 0;
	int compares = 0;
	int i;
	logic [15:0] rq[$];
	logic [3:0] nq[$];
	logic rd_pend = 1'b0;
	logic skip5 = 1'b0;

	always #12.5 CLOCK = ~CLOCK;

	// ==========================================================
	// loopback and shared strap pins
	assign #7 LINE_RX_CLK = LINE_TX_CLK;
	assign #7 LINE_RX_DATA = LINE_TX_DATA;
	assign LINE_RX_PULSE = LINE_TX_PULSE;
	assign LED_IN = (LED_OUT & ~LED_OE_N) | (strap & LED_OE_N);

	phy_stream_framing #(.NLP_PERIOD_CYCLES(200), .LINK_TIMEOUT_CYCLES(2000))
	u_dut (.CLOCK(CLOCK), .RESET_N(RESET_N), .ADDRESS(ADDRESS),
		.WRITE_DATA(WRITE_DATA), .WRITE_STROBE(WRITE_STROBE),
		.READ_STROBE(READ_STROBE), .READ_DATA(READ_DATA), .TXD(TXD),
		.TX_EN(TX_EN), .MII_TX_CLK(MII_TX_CLK), .RXD(RXD), .RX_DV(RX_DV),
		.RX_ER(RX_ER), .MII_RX_CLK(MII_RX_CLK), .LINE_TX_DATA(LINE_TX_DATA),
		.LINE_TX_CLK(LINE_TX_CLK), .LINE_TX_PULSE(LINE_TX_PULSE),
		.LINE_RX_DATA(LINE_RX_DATA), .LINE_RX_CLK(LINE_RX_CLK),
		.LINE_RX_PULSE(LINE_RX_PULSE), .LED_IN(LED_IN), .LED_OUT(LED_OUT),
		.LED_OE_N(LED_OE_N));

	mac_model u_mac (.clock(CLOCK), .tx_clk(MII_TX_CLK), .txd(TXD),
		.tx_en(TX_EN));

	// ==========================================================
	// checking and closing
	task chk(input logic [15:0] s, input logic [15:0] e);
		compares++;
		if (s !== e)
		begin
			n_errors++;
			$display("[ERR] %0t seen %h expected %h", $time, s, e);
		end
	endtask

	task stop_test;
		if (n_errors == 0 && compares > 0)
			$display("Testbench passed");
		else
			$display("Testbench failed");
		$finish;
	endtask

	task fail_if(input bit bad);
		if (bad)
		begin
			n_errors++;
			stop_test;
		end
	endtask

	// ==========================================================
	// register bus and frame drivers
	task wr(input logic [3:0] a, input logic [15:0] d);
		ADDRESS <= a;
		WRITE_DATA <= d;
		WRITE_STROBE <= 1'b1;
		@(posedge CLOCK);
		WRITE_STROBE <= 1'b0;
	endtask

	task rd(input logic [3:0] a, input logic [15:0] e);
		rq.push_back(e);
		ADDRESS <= a;
		READ_STROBE <= 1'b1;
		@(posedge CLOCK);
		READ_STROBE <= 1'b0;
	endtask

	task frame(input bit ten);
		logic [3:0] n;
		skip5 = ten;
		for (i = 0; i < 24; i++)
		begin
			n = i < 15 ? 4'h5 : i == 15 ? 4'hD : 4'($random(seed));
			u_mac.push(n);
			if (!ten || i >= 15)
				nq.push_back(n);
		end
		for (i = 0; i < 20000 && nq.size() > 0; i++)
			@(posedge CLOCK);
		fail_if(nq.size() > 0);
	endtask

	always @(posedge CLOCK)
	begin
		rd_pend <= READ_STROBE;
		if (rd_pend)
			chk(READ_DATA, rq.pop_front());
		if (MII_RX_CLK && RX_DV && !(skip5 && RXD === 4'h5))
		begin
			skip5 <= 1'b0;
			if (nq.size() > 0)
				chk({11'h000, RX_ER, RXD}, {12'h000, nq.pop_front()});
			else
				chk({12'h000, RXD}, 16'hFFFF);
		end
	end

	// ==========================================================
	// main sequence
	initial
	begin
		strap = 5'($random(seed));
		repeat (6) @(posedge CLOCK);
		RESET_N <= 1'b1;
		rd(REG_CONTROL, CTL_RESET);
		wr(REG_CONTROL, 16'h0001);
		repeat (4) @(posedge CLOCK);
		rd(REG_EXT_CONTROL, {5'h00, strap, 6'h00});
		wr(REG_NEXT_PAGE, 16'hFFFF);
		rd(REG_NEXT_PAGE, 16'h07FF);
		wr(4'hA, 16'hFFFF);
		rd(4'hA, 16'h0000);
		for (i = 0; i < 5000 && LED_OUT[0] !== 1'b1; i++)
			@(posedge CLOCK);
		fail_if(LED_OUT[0] !== 1'b1);
		rd(REG_STATUS, 16'h001B);
		frame(1'b0);
		// let the end delimiter drain before the speed change
		repeat (200) @(posedge CLOCK);
		wr(REG_CONTROL, 16'h0000);
		for (i = 0; i < 1000 && LINE_TX_PULSE !== 1'b1; i++)
			@(posedge CLOCK);
		fail_if(LINE_TX_PULSE !== 1'b1);
		repeat (20) @(posedge CLOCK);
		rd(REG_STATUS, 16'h0019);
		chk({11'h000, LED_OUT}, 16'h0001);
		frame(1'b1);
		wr(REG_CONTROL, 16'h0004);
		repeat (2) @(posedge CLOCK);
		rd(REG_STATUS, 16'h002D);
		repeat (50) @(posedge CLOCK);
		stop_test;
	end
endmodule
